// ### sbsp_burst.sv
`timescale 1ns/1ns
module sbsp_burst
#(
   parameter int W = sbsp_pkg::BURST_W
)
(
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic         load,
   input  wire logic         step,
   input  wire logic         linear,
   input  wire logic [W-1:0] start_lsbs,
   output logic      [W-1:0] cur_lsbs
);
   logic [W-1:0] preset_r;
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic [W-1:0] base;

   // ----------------------------------------
   // Counter and order
   // ----------------------------------------
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (load)
         cnt_nxt = '0;
      else if (step)
         cnt_nxt = cnt_r + W'(sbsp_pkg::BURST_ONE);
      base = load ? start_lsbs : preset_r;
      cur_lsbs = linear ? W'(base + cnt_nxt) : (base ^ cnt_nxt);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         preset_r <= '0;
      else if (ce && load)
         preset_r <= start_lsbs;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         cnt_r <= '0;
      else if (ce)
         cnt_r <= cnt_nxt;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   load_clears_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (ce && load) |=> (cnt_r == '0 && preset_r == $past(start_lsbs)))
      else $error("burst load did not preset counter");

   step_incr_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (ce && step && !load) |=> (cnt_r == W'($past(cnt_r) + W'(sbsp_pkg::BURST_ONE))))
      else $error("burst counter did not advance by one");
endmodule

// ### sbsp_ctrl_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host controller: late write data on bus
// ----------------------------------------
module sbsp_ctrl_model
(
   input  wire logic                        core_clk,
   input  wire logic                        resetn,
   input  wire logic                        cke_n,
   input  wire logic                        pipe,
   input  wire logic                        sel,
   input  wire logic                        step,
   input  wire logic                        we_n,
   input  wire logic [sbsp_pkg::DATA_W-1:0] wdata,
   input  wire logic                        dut_oe,
   input  wire logic [sbsp_pkg::DATA_W-1:0] dut_o,
   output logic      [sbsp_pkg::DATA_W-1:0] bus
);
   logic [1:0]                  wr_r;
   logic [sbsp_pkg::DATA_W-1:0] d1_r, d2_r, last_r;
   logic                        wop_r, drv;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
      begin
         wr_r <= 2'h0;
         wop_r <= 1'b0;
      end
      else if (!cke_n)
      begin
         if (!step)
            wop_r <= sel & ~we_n;
         wr_r <= {wr_r[0], step ? wop_r : sel & ~we_n};
         d1_r <= wdata;
         d2_r <= d1_r;
      end
   assign drv = pipe ? wr_r[1] : wr_r[0];
   // Released bus inverts each cycle so stale data never passes
   always_ff @(posedge core_clk)
      last_r <= bus;
   // Both parties driving shows as unknown
   assign bus = dut_oe ? (drv ? 'x : dut_o) : drv ? (pipe ? d2_r : d1_r) : ~last_r;
endmodule

// ### sbsp_parity.sv
`timescale 1ns/1ns
module sbsp_parity
(
   input  wire logic [sbsp_pkg::DATA_W-1:0] data,
   input  wire logic                        odd,
   output logic      [sbsp_pkg::LANES-1:0]  lane_err
);
   localparam int LW = sbsp_pkg::LANE_W;

   // ----------------------------------------
   // Per-lane check over all nine bits
   // ----------------------------------------
   for (genvar g = 0; g < sbsp_pkg::LANES; g++)
   begin : g_lane
      assign lane_err[g] = (^data[g*LW +: LW]) ^ odd;
   end
endmodule

// ### sbsp_pkg.sv
package sbsp_pkg;
   // ----------------------------------------
   // Data path geometry
   // ----------------------------------------
   localparam int LANES   = 8;
   localparam int LANE_W  = 9;
   localparam int DATA_W  = 72;
   localparam int BURST_W = 2;
   localparam int AXI_AW  = 4;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_STAT    = 4'h4;
   localparam int         CTRL_ODD    = 0;
   localparam int         STAT_WPE    = 0;
   localparam int         STAT_RPE    = 1;
   localparam int         STAT_SLEEP  = 2;
   localparam int         STAT_FLOW   = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic             ODD_RST    = 1'b0;
   localparam logic             FLOW_RST   = 1'b1;
   localparam logic             LINEAR_RST = 1'b1;
   localparam logic             GATE_RST   = 1'b1;
   localparam logic [LANES-1:0] MASK_NONE  = 8'hFF;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

   // ----------------------------------------
   // Commands
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      OP_IDLE  = 3'h1,
      OP_READ  = 3'h2,
      OP_WRITE = 3'h4
   } sbsp_op_t;

   typedef struct packed
   {
      sbsp_op_t         op;
      logic [LANES-1:0] mask_n;
   } sbsp_cmd_t;

   localparam sbsp_cmd_t CMD_IDLE = '{op: OP_IDLE, mask_n: MASK_NONE};
endpackage

// ### sbsp_port.sv
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
// Function
// - Address, data and controls are sampled only at rising clock edges
// - Active-low output enable forces data drivers off at once, asynchronously
// - Sleep input, active high and asynchronous, puts device to sleep; drivers drop at once, sleep itself is taken after two enabled edges
// - Write is launched by a clock edge and completes internally
// - Pipelined reads drive data one edge later, 3-1-1-1 bursts
// - Low mode select means flow-through, 2-1-1-1 bursts; high pipelined
// - Reads and writes follow back to back, no idle cycles
// - Eight 9-bit lanes, each written only while its mask is low
// - Low write strobe selects write of lanes masked active
// - Selected only when both low selects and high select are active
// - Burst step high advances internal counter instead of loading address
// - Two low address bits preset the burst counter on load
// - Order select low linear, high interleaved; held static
// - Only edges with the active-low clock gate low are acted on
// - Write data parity checked, even or odd; stored parity checked
// - Pipelined write data is taken at third edge, command edge counted first
// - Flow-through write data is taken at second edge, command edge counted first
// - Write with no lane mask active changes nothing
// - Two-bit burst counter increments on every continue cycle
module sbsp_port
#(
   parameter int ADDR_W = 18
)
(
   input  wire logic                           core_clk,
   input  wire logic                           resetn,
   input  wire logic                           cke_n,
   input  wire logic [ADDR_W-3:0]              addr_upper,
   input  wire logic [1:0]                     burst_start_lsbs,
   input  wire logic                           burst_step,
   input  wire logic                           we_n,
   input  wire logic [sbsp_pkg::LANES-1:0]     byte_mask_n,
   input  wire logic                           chip_select_low_first,
   input  wire logic                           chip_select_high,
   input  wire logic                           chip_select_low_third,
   input  wire logic                           out_drive_n,
   input  wire logic                           sleep_request,
   input  wire logic                           flow_thru_select,
   input  wire logic                           linear_order_select,
   input  wire logic [sbsp_pkg::DATA_W-1:0]    byte_lane_io_i,
   output logic      [sbsp_pkg::DATA_W-1:0]    byte_lane_io_o,
   output logic                                byte_lane_io_oe,
   output logic                                sleep_state,
   input  wire logic [sbsp_pkg::AXI_AW-1:0]    s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic      [1:0]                     s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [sbsp_pkg::AXI_AW-1:0]    s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic      [31:0]                    s_axi_rdata,
   output logic      [1:0]                     s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready
);
   localparam int DW = sbsp_pkg::DATA_W;
   localparam int LW = sbsp_pkg::LANE_W;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pin_m_r;
   logic [3:0] pin_s_r;
   logic       sleep_s;
   logic       gate_s;
   logic       flow_mode;
   logic       linear;
   logic       ce;
   logic       act;

   // Static straps still cross two stages; only the first feeds the second
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_m_r <= {sbsp_pkg::LINEAR_RST, sbsp_pkg::FLOW_RST, sbsp_pkg::GATE_RST, 1'b0};
         pin_s_r <= {sbsp_pkg::LINEAR_RST, sbsp_pkg::FLOW_RST, sbsp_pkg::GATE_RST, 1'b0};
      end
      else if (ce)
      begin
         pin_m_r <= {linear_order_select, flow_thru_select, out_drive_n, sleep_request};
         pin_s_r <= pin_m_r;
      end
   end

   assign sleep_s   = pin_s_r[0];
   assign gate_s    = pin_s_r[1];
   assign flow_mode = !pin_s_r[2];
   assign linear    = !pin_s_r[3];
   assign ce        = !cke_n;
   assign act       = ce && !sleep_s;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   sbsp_pkg::sbsp_op_t  last_op_r;
   sbsp_pkg::sbsp_cmd_t cmd_now;
   sbsp_pkg::sbsp_cmd_t s1_r;
   sbsp_pkg::sbsp_cmd_t s2_r;
   logic [ADDR_W-3:0]   upper_r;
   logic [ADDR_W-1:0]   addr_now;
   logic [ADDR_W-1:0]   a1_r;
   logic [ADDR_W-1:0]   a2_r;
   logic [1:0]          cur_lsbs;
   logic                sel;

   assign sel = !chip_select_low_first && chip_select_high && !chip_select_low_third;

   // Any op may follow any op, so the bus never needs a turnaround slot
   always_comb
   begin
      cmd_now = sbsp_pkg::CMD_IDLE;
      cmd_now.mask_n = byte_mask_n;
      if (sleep_s)
         cmd_now.op = sbsp_pkg::OP_IDLE;
      else if (burst_step)
         cmd_now.op = last_op_r;
      else if (sel)
         cmd_now.op = we_n ? sbsp_pkg::OP_READ : sbsp_pkg::OP_WRITE;
      addr_now = {burst_step ? upper_r : addr_upper, cur_lsbs};
   end

   sbsp_burst u_burst
   (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .ce         (act),
      .load       (!burst_step),
      .step       (burst_step),
      .linear     (linear),
      .start_lsbs (burst_start_lsbs),
      .cur_lsbs   (cur_lsbs)
   );

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         last_op_r <= sbsp_pkg::OP_IDLE;
         upper_r   <= '0;
      end
      else if (act)
      begin
         last_op_r <= cmd_now.op;
         if (!burst_step)
            upper_r <= addr_upper;
      end
   end

   // Pipeline of command stages, frozen by the clock gate
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_r <= sbsp_pkg::CMD_IDLE;
         s2_r <= sbsp_pkg::CMD_IDLE;
         a1_r <= '0;
         a2_r <= '0;
      end
      else if (ce)
      begin
         s1_r <= cmd_now;
         s2_r <= s1_r;
         a1_r <= addr_now;
         a2_r <= a1_r;
      end
   end

   // ----------------------------------------
   // Storage and write path
   // ----------------------------------------
   logic [DW-1:0]                mem [0:(2**ADDR_W)-1];
   sbsp_pkg::sbsp_cmd_t          wr_cmd;
   logic [ADDR_W-1:0]            wr_addr;
   logic                         wr_en;
   logic [DW-1:0]                wr_old;
   logic [sbsp_pkg::LANES-1:0]   wp_err;
   logic [sbsp_pkg::LANES-1:0]   rp_err;
   logic                         odd_r;

   assign wr_cmd  = flow_mode ? s1_r : s2_r;
   assign wr_addr = flow_mode ? a1_r : a2_r;
   assign wr_en   = ce && (wr_cmd.op == sbsp_pkg::OP_WRITE);
   assign wr_old  = mem[wr_addr];

   // No write pulse leaves the block: the edge itself commits the lanes
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
      begin
         for (int l = 0; l < sbsp_pkg::LANES; l++)
         begin
            if (!wr_cmd.mask_n[l])
               mem[wr_addr][l*LW +: LW] <= byte_lane_io_i[l*LW +: LW];
         end
      end
   end

   sbsp_parity u_wpar
   (
      .data     (byte_lane_io_i),
      .odd      (odd_r),
      .lane_err (wp_err)
   );

   // ----------------------------------------
   // Read path and drivers
   // ----------------------------------------
   logic          rd_go;
   logic [DW-1:0] rd_word;
   logic [DW-1:0] dq_out_r;
   logic          dq_oe_r;
   logic          drv_kill;

   assign rd_go   = flow_mode ? (cmd_now.op == sbsp_pkg::OP_READ)
                              : (s1_r.op == sbsp_pkg::OP_READ);
   assign rd_word = mem[flow_mode ? addr_now : a1_r];
   assign drv_kill = out_drive_n || sleep_request || !resetn;

   sbsp_parity u_rpar
   (
      .data     (rd_word),
      .odd      (odd_r),
      .lane_err (rp_err)
   );

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         dq_out_r <= '0;
      else if (ce && rd_go)
         dq_out_r <= rd_word;
   end

   // Asynchronous kill keeps the override immediate yet the pin on a flop
   always_ff @(posedge core_clk or posedge drv_kill)
   begin
      if (drv_kill)
         dq_oe_r <= 1'b0;
      else if (ce)
         dq_oe_r <= rd_go && !gate_s && !sleep_s;
   end

   assign byte_lane_io_o  = dq_out_r;
   assign byte_lane_io_oe = dq_oe_r;

   // ----------------------------------------
   // Status and control
   // ----------------------------------------
   logic [1:0] err_r;
   logic       sleep_state_r;
   logic       wr_hs;
   logic       rd_hs;
   logic       stat_w1c;

   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_hs = s_axi_arvalid && s_axi_arready;
   assign stat_w1c = wr_hs && s_axi_wstrb[0] && (s_axi_awaddr == sbsp_pkg::REG_STAT);

   // Set beats clear when both land in one edge
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         err_r <= '0;
      else if (ce)
      begin
         if (stat_w1c)
            err_r <= err_r & ~s_axi_wdata[sbsp_pkg::STAT_RPE:sbsp_pkg::STAT_WPE];
         if (wr_en && |(wp_err & ~wr_cmd.mask_n))
            err_r[sbsp_pkg::STAT_WPE] <= 1'b1;
         if (rd_go && |rp_err)
            err_r[sbsp_pkg::STAT_RPE] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         odd_r <= sbsp_pkg::ODD_RST;
      else if (ce && wr_hs && s_axi_wstrb[0] && (s_axi_awaddr == sbsp_pkg::REG_CTRL))
         odd_r <= s_axi_wdata[sbsp_pkg::CTRL_ODD];
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         sleep_state_r <= 1'b0;
      else if (ce)
         sleep_state_r <= sleep_s;
   end

   assign sleep_state = sleep_state_r;

   // ----------------------------------------
   // Register bus slave
   // ----------------------------------------
   logic [31:0] rd_mux;
   logic        wmap;
   logic        rmap;

   assign wmap = (s_axi_awaddr == sbsp_pkg::REG_CTRL) || (s_axi_awaddr == sbsp_pkg::REG_STAT);
   assign rmap = (s_axi_araddr == sbsp_pkg::REG_CTRL) || (s_axi_araddr == sbsp_pkg::REG_STAT);

   always_comb
   begin
      rd_mux = '0;
      if (s_axi_araddr == sbsp_pkg::REG_CTRL)
         rd_mux[sbsp_pkg::CTRL_ODD] = odd_r;
      else if (s_axi_araddr == sbsp_pkg::REG_STAT)
      begin
         rd_mux[sbsp_pkg::STAT_RPE:sbsp_pkg::STAT_WPE] = err_r;
         rd_mux[sbsp_pkg::STAT_SLEEP] = sleep_state_r;
         rd_mux[sbsp_pkg::STAT_FLOW] = flow_mode;
      end
   end

   // Address and data are taken together, one write in flight
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= sbsp_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wr_hs)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wmap ? sbsp_pkg::RESP_OKAY : sbsp_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= sbsp_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_hs)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rmap ? sbsp_pkg::RESP_OKAY : sbsp_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   oe_override_a: assert property (out_drive_n |-> !dq_oe_r)
      else $error("drivers on while output enable high");

   sleep_off_a: assert property (sleep_request |-> !dq_oe_r)
      else $error("drivers on while sleep requested");

   flow_read_a: assert property (
      (ce && flow_mode && !sleep_s && cmd_now.op == sbsp_pkg::OP_READ)
      |=> (dq_oe_r || out_drive_n || sleep_request || gate_s))
      else $error("flow-through read not driven after one edge");

   pipe_read_a: assert property (
      (ce && !flow_mode && !sleep_s && cmd_now.op == sbsp_pkg::OP_READ) ##1 (ce && !flow_mode)
      |=> (dq_oe_r || out_drive_n || sleep_request || gate_s))
      else $error("pipelined read not driven after two edges");

   write_quiet_a: assert property (
      (ce && wr_cmd.op == sbsp_pkg::OP_WRITE)
      |-> !dq_oe_r)
      else $error("drivers on during write data cycle");

   mask_nop_a: assert property (
      (wr_en && wr_cmd.mask_n == sbsp_pkg::MASK_NONE) |=> (mem[$past(wr_addr)] == $past(wr_old)))
      else $error("write with no lane enabled changed storage");

   lane_write_a: assert property (
      (wr_en && !wr_cmd.mask_n[0]) |=> (mem[$past(wr_addr)][LW-1:0] == $past(byte_lane_io_i[LW-1:0])))
      else $error("enabled lane not written");

   deselect_a: assert property (
      (ce && !burst_step && !sel) |=> (s1_r.op == sbsp_pkg::OP_IDLE))
      else $error("command taken while deselected");

   gate_hold_a: assert property (!ce |=> ($stable(s1_r) && $stable(dq_out_r)))
      else $error("state moved on a gated edge");

   back_to_back_a: assert property (
      (act && cmd_now.op == sbsp_pkg::OP_READ) ##1 (act && !burst_step && sel && !we_n)
      |=> (s1_r.op == sbsp_pkg::OP_WRITE && s2_r.op == sbsp_pkg::OP_READ))
      else $error("write after read not taken back to back");

   parity_flag_a: assert property (
      (wr_en && |(wp_err & ~wr_cmd.mask_n)) |=> err_r[sbsp_pkg::STAT_WPE])
      else $error("write parity error not flagged");

   write_delay_a: assert property (
      (act && !flow_mode && cmd_now.op == sbsp_pkg::OP_WRITE) ##1 ce ##1 (ce && !flow_mode)
      |-> wr_en)
      else $error("pipelined write not committed at third edge");
endmodule

// ### test_sync_burst_sram_port.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin error_cnt++; \
   $display("[ERR] %s expected %h seen %h", n, e, s); end end
module test_sync_burst_sram_port;
   localparam int AW = 5;
   typedef logic [sbsp_pkg::DATA_W-1:0] sbsp_word_t;
   logic core_clk = 1'b0, resetn = 1'b0, cke_n = 1'b0, step = 1'b0, we_n = 1'b1;
   logic drv_n = 1'b0, slp = 1'b0, pipe = 1'b1, lo = 1'b0, act_r = 1'b0, asleep = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic awr, wr, bv, arr, rv, oe, sst;
   logic [1:0] bresp, rresp, cnt;
   logic [2:0] csel = 3'h0;
   logic [3:0] awa = 4'h0, ara = 4'h0;
   logic [7:0] mask_n = 8'hFF;
   logic [31:0] wd = 32'h0, rd, xs_s = 32'h13;
   logic [AW-1:0] addr = '0, base;
   sbsp_word_t wdata = '0, bus, o, mem [2**AW], exp_q[$];
   int error_cnt = 0, samples_checked = 0, ncyc = 0, op = 0, due_q[$];

   always #5 core_clk = ~core_clk;
   sbsp_port #(.ADDR_W(AW)) u_dut (.core_clk, .resetn, .cke_n, .addr_upper(addr[AW-1:2]),
      .burst_start_lsbs(addr[1:0]), .burst_step(step), .we_n, .byte_mask_n(mask_n),
      .chip_select_low_first(csel[2]), .chip_select_high(csel[1]),
      .chip_select_low_third(csel[0]), .out_drive_n(drv_n), .sleep_request(slp),
      .flow_thru_select(pipe), .linear_order_select(lo), .byte_lane_io_i(bus),
      .byte_lane_io_o(o), .byte_lane_io_oe(oe), .sleep_state(sst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready));
   sbsp_ctrl_model u_ctrl (.core_clk, .resetn, .cke_n, .pipe, .sel(csel == 3'h2), .step,
      .we_n, .wdata, .dut_oe(oe), .dut_o(o), .bus);

   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      xs_s ^= xs_s << 13;
      xs_s ^= xs_s >> 17;
      xs_s ^= xs_s << 5;
      return xs_s;
   endfunction
   // Clean even parity per lane
   function automatic sbsp_word_t rw();
      sbsp_word_t d;
      d[71:64] = 8'(xs());
      d[63:0] = {xs(), xs()};
      for (int l = 0; l < 8; l++)
         d[9*l+8] = ^d[9*l+:8];
      return d;
   endfunction
   function automatic logic [AW-1:0] baddr(logic [AW-1:0] b, logic [1:0] c);
      return {b[AW-1:2], lo ? b[1:0] ^ c : b[1:0] + c};
   endfunction

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic cmd(logic w, logic s, logic [AW-1:0] a, logic [7:0] m, logic [2:0] cs,
                      sbsp_word_t d);
      logic [AW-1:0] ea;
      @(posedge core_clk);
      cke_n <= 1'b0;
      we_n <= ~w;
      step <= s;
      addr <= a;
      mask_n <= m;
      csel <= cs;
      wdata <= d;
      if (s)
         cnt++;
      else
      begin
         base = a;
         cnt = 2'h0;
         op = cs != 3'h2 ? 0 : w ? 2 : 1;
      end
      ea = baddr(base, cnt);
      if (op == 2 && !asleep)
         for (int l = 0; l < 8; l++)
            if (!m[l])
               mem[ea][9*l+:9] = d[9*l+:9];
      if (op == 1 && !asleep)
      begin
         due_q.push_back(ncyc + (pipe ? 3 : 2));
         exp_q.push_back(mem[ea]);
      end
   endtask
   task automatic idle(int n);
      repeat (n) cmd(1'b0, 1'b0, '0, 8'hFF, 3'h0, '0);
   endtask
   task automatic burst(logic w, logic [AW-1:0] a, int n, logic [7:0] m);
      for (int i = 0; i < n; i++)
         cmd(w, i > 0, a, m, 3'h2, rw());
   endtask
   task automatic axi(logic w, logic [3:0] a, logic [31:0] d, logic [1:0] er,
                      output logic [31:0] v);
      int n;
      n = 0;
      @(posedge core_clk);
      awa <= a;
      ara <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      bready <= w;
      arv <= !w;
      rready <= !w;
      do
      begin
         @(posedge core_clk);
         n++;
         if (awr)
            awv <= 1'b0;
         if (wr)
            wv <= 1'b0;
         if (arr)
            arv <= 1'b0;
         if (bv && bready)
         begin
            `CHK("bresp", er, bresp)
            bready <= 1'b0;
         end
         if (rv && rready)
         begin
            `CHK("rresp", er, rresp)
            v = rd;
            rready <= 1'b0;
         end
      end
      while ((awv || wv || bready || arv || rready) && n < 50);
      `CHK("axi done", 1'b1, n < 50)
   endtask

   // ----------------------------------------
   // Read data monitor
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      act_r <= !cke_n;
      if (!cke_n)
         ncyc <= ncyc + 1;
   end
   always @(negedge core_clk)
      if (resetn && act_r)
      begin
         if (due_q.size() > 0 && due_q[0] == ncyc)
         begin
            `CHK("read oe", !(drv_n || slp), oe)
            if (!drv_n)
               `CHK("read data", exp_q[0], o)
            void'(due_q.pop_front());
            void'(exp_q.pop_front());
         end
         else
            `CHK("idle oe", 1'b0, oe)
      end

   task automatic conclude();
      $display("checked %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      conclude();
   end

   initial
   begin
      logic [31:0] v;
      for (int r = 0; r < 4; r++)
      begin
         @(posedge core_clk);
         resetn <= 1'b0;
         pipe <= r[0];
         lo <= r[1];
         repeat (2) @(posedge core_clk);
         `CHK("reset outs", 4'h0, {oe, sst, bv, rv})
         resetn <= 1'b1;
         due_q.delete();
         exp_q.delete();
         idle(3);
         for (int b = 0; b < 2**AW; b += 4)
            burst(1'b1, AW'(b) | AW'(xs() % 4), 4, 8'h00);
         // Writes upper half, reads lower half: no in-flight overlap
         for (int i = 0; i < 40; i++)
         begin
            v = xs();
            if (v[3:1] == 3'h0)
            begin
               cmd(v[0], 1'b0, '0, 8'h00, v[26:24] == 3'h2 ? 3'h7 : v[26:24], rw());
               cmd(1'b1, 1'b1, '0, 8'h00, 3'h2, rw());
            end
            else
               burst(v[0], {v[0], v[AW+6:8]}, int'(v[31:30]) + 1,
                     v[5:4] == 2'h0 ? 8'hFF : v[23:16]);
         end
         burst(1'b0, '0, 2, 8'hFF);
         drv_n <= 1'b1;
         burst(1'b0, AW'(4), 2, 8'hFF);
         idle(3);
         drv_n <= 1'b0;
         idle(3);
         burst(1'b0, AW'(8), 2, 8'hFF);
         @(posedge core_clk);
         cke_n <= 1'b1;
         repeat (2) @(posedge core_clk);
         idle(3);
         slp <= 1'b1;
         idle(4);
         `CHK("sleep state", 1'b1, sst)
         asleep = 1'b1;
         burst(1'b1, AW'(4), 2, 8'h00);
         burst(1'b0, '0, 1, 8'hFF);
         idle(1);
         slp <= 1'b0;
         asleep = 1'b0;
         idle(4);
         for (int b = 0; b < 2**AW; b += 4)
            burst(1'b0, AW'(b) | AW'(xs() % 4), 4, 8'hFF);
         idle(3);
         axi(1'b0, sbsp_pkg::REG_STAT, 32'h0, sbsp_pkg::RESP_OKAY, v);
         `CHK("stat clean", 3'h0, v[2:0])
         cmd(1'b1, 1'b0, '0, 8'hF7, 3'h2, rw() ^ (72'h1 << 35));
         idle(2);
         burst(1'b0, '0, 1, 8'hFF);
         idle(3);
         axi(1'b0, sbsp_pkg::REG_STAT, 32'h0, sbsp_pkg::RESP_OKAY, v);
         `CHK("stat errors", 2'h3, v[1:0])
         axi(1'b1, sbsp_pkg::REG_STAT, 32'h3, sbsp_pkg::RESP_OKAY, v);
         axi(1'b0, sbsp_pkg::REG_STAT, 32'h0, sbsp_pkg::RESP_OKAY, v);
         `CHK("stat cleared", 2'h0, v[1:0])
         axi(1'b1, sbsp_pkg::REG_CTRL, 32'h1, sbsp_pkg::RESP_OKAY, v);
         axi(1'b0, sbsp_pkg::REG_CTRL, 32'h0, sbsp_pkg::RESP_OKAY, v);
         `CHK("odd select", 1'b1, v[0])
         axi(1'b0, 4'h8, 32'h0, sbsp_pkg::RESP_SLVERR, v);
         axi(1'b1, 4'hC, 32'h5, sbsp_pkg::RESP_SLVERR, v);
         $display("run %0d done", r);
      end
      conclude();
   end
endmodule
